// ---- hwcfg_consts.svh ----
// offsets, field positions, reset values and timing counts of the configuration bank
`ifndef HWCFG_CONSTS_SVH
`define HWCFG_CONSTS_SVH
// register offsets on the plain port
`define OFS_PIN_BUS 8'ha6
`define OFS_CLK_GAIN 8'ha8
`define OFS_GATE_DRV 8'hac
// reset values
`define RST_PIN_BUS 32'h0000_0000
`define RST_CLK_GAIN 32'h0000_0000
`define RST_GATE_DRV 32'h1022_8100
// pin_and_bus_setup fields
`define POS_SHARED_PIN_SEL 29
`define POS_SPEED_PIN_ROLE 28
`define POS_CRYSTAL_PIN_SEL 27
`define POS_MAX_SUPPLY_RANGE 0
// clock_and_gain_setup fields
`define POS_AUTO_CURRENT_GAIN 13
`define POS_AUTO_VOLTAGE_GAIN 12
`define POS_LOW_POWER_STATE 11
`define POS_SPEED_PWM_RANGE 10
`define POS_CLOCK_SOURCE 8
`define POS_REF_CLOCK_MODE 6
`define POS_REF_CLOCK_RATE 3
// gate_driver_setup fields
`define POS_CURRENT_AMP_GAIN 0
// gain re-evaluation period
`define CLK_PERIOD_NS 4
`define GAIN_EVAL_PERIOD_NS 1000000
`define GAIN_EVAL_CYCLES (`GAIN_EVAL_PERIOD_NS / `CLK_PERIOD_NS)
// accepted speed pwm spans, hz
`define SPEED_WIDE_MIN_HZ 100
`define SPEED_WIDE_MAX_HZ 100000
`define SPEED_LOW_MIN_HZ 10
`define SPEED_LOW_MAX_HZ 10000
`endif

// ---- hwcfg_pkg.sv ----
// types of the configuration bank
package hwcfg_pkg;
  typedef enum logic [1:0] {
    SHARED_MONITOR_B = 2'h0,
    SHARED_PHASE_A = 2'h1,
    SHARED_PHASE_B = 2'h2,
    SHARED_PHASE_C = 2'h3
  } shared_pin_sel_t;
  typedef enum logic [1:0] {
    CLK_INTERNAL = 2'h0,
    CLK_WATCHDOG_OSC = 2'h1,
    CLK_CRYSTAL = 2'h2,
    CLK_EXTERNAL = 2'h3
  } clock_source_t;
  // decoded settings that steer the rest of the device
  typedef struct packed {
    logic [1:0] max_supply_range;
    logic low_power_state_sel;
    logic speed_pwm_range_sel;
    clock_source_t clock_source;
    logic ref_clock_mode_enable;
    logic [2:0] ref_clock_rate_sel;
    logic [1:0] current_amp_gain;
    logic auto_current_gain_enable;
    logic auto_voltage_gain_enable;
    logic [31:0] speed_pwm_min_hz;
    logic [31:0] speed_pwm_max_hz;
  } hw_settings_t;
  // signals bound for the pins
  typedef struct packed {
    logic shared_pin;
    logic pin_36;
    logic pin_37;
  } pin_drive_t;
endpackage

// ---- hw_pin_clock_config_regs.sv ----
// hardware pin, clock and gain configuration register bank
`timescale 1ns/1ns
`include "hwcfg_consts.svh"
module hw_pin_clock_config_regs #(
  parameter int GAIN_EVAL_CYCLES = `GAIN_EVAL_CYCLES
) (
  // clock and reset
  input wire logic MCLK_IN,
  input wire logic RESETN_IN,
  // register port
  input wire logic [7:0] ADDR_IN,
  input wire logic [31:0] WDATA_IN,
  input wire logic WR_IN,
  input wire logic RD_IN,
  output logic [31:0] RDATA_OUT,
  // sources for the shared pins
  input wire logic MONITOR_A_IN,
  input wire logic MONITOR_B_IN,
  input wire logic PHASE_A_SENSE_IN,
  input wire logic PHASE_B_SENSE_IN,
  input wire logic PHASE_C_SENSE_IN,
  input wire logic CRYSTAL_DRIVE_IN,
  // speed pin and gain adjustment
  input wire logic SPEED_PIN_IN,
  input wire logic [1:0] AUTO_CURRENT_GAIN_IN,
  output logic SPEED_CMD_OUT,
  output logic WAKE_OUT,
  output logic CURRENT_GAIN_EVAL_OUT,
  output logic VOLTAGE_GAIN_EVAL_OUT,
  output logic [1:0] EFFECTIVE_CURRENT_GAIN_OUT,
  // pin drive and settings
  output hwcfg_pkg::pin_drive_t PINS_OUT,
  output logic CRYSTAL_ENABLE_OUT,
  output hwcfg_pkg::hw_settings_t SETTINGS_OUT
);
  import hwcfg_pkg::*;

  logic [31:0] pin_bus_reg;
  logic [31:0] clk_gain_reg;
  logic [31:0] gate_drv_reg;
  logic [1:0] speed_sync_reg;
  logic [$clog2(GAIN_EVAL_CYCLES)-1:0] tick_cnt_reg;
  logic tick;
  logic auto_cur;
  logic auto_volt;
  shared_pin_sel_t shared_sel;

  // static current amp gain field of the gate driver word
  function automatic logic [1:0] static_gain(input logic [31:0] word);
    return word[`POS_CURRENT_AMP_GAIN +: 2];
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // register port

  // writes store the whole word, reserved bits included
  always_ff @(posedge MCLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      pin_bus_reg <= `RST_PIN_BUS;
      clk_gain_reg <= `RST_CLK_GAIN;
      gate_drv_reg <= `RST_GATE_DRV;
    end else if (WR_IN) begin
      case (ADDR_IN)
        `OFS_PIN_BUS: pin_bus_reg <= WDATA_IN;
        `OFS_CLK_GAIN: clk_gain_reg <= WDATA_IN;
        `OFS_GATE_DRV: gate_drv_reg <= WDATA_IN;
        default: ;
      endcase
    end
  end

  // read data one cycle after the strobe, zero on unmapped offsets
  always_ff @(posedge MCLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      RDATA_OUT <= 32'h0000_0000;
    end else if (RD_IN) begin
      case (ADDR_IN)
        `OFS_PIN_BUS: RDATA_OUT <= pin_bus_reg; // reserved bits kept for rmw
        `OFS_CLK_GAIN: RDATA_OUT <= clk_gain_reg;
        `OFS_GATE_DRV: RDATA_OUT <= gate_drv_reg;
        default: RDATA_OUT <= 32'h0000_0000;
      endcase
    end else begin
      RDATA_OUT <= 32'h0000_0000;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // field decode

  assign auto_cur = clk_gain_reg[`POS_AUTO_CURRENT_GAIN];
  assign auto_volt = clk_gain_reg[`POS_AUTO_VOLTAGE_GAIN];
  assign shared_sel = shared_pin_sel_t'(pin_bus_reg[`POS_SHARED_PIN_SEL +: 2]);

  // settings word, registered so it changes one cycle after the write
  always_ff @(posedge MCLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      SETTINGS_OUT <= '0;
    end else begin
      SETTINGS_OUT.max_supply_range <= pin_bus_reg[`POS_MAX_SUPPLY_RANGE +: 2];
      SETTINGS_OUT.low_power_state_sel <= clk_gain_reg[`POS_LOW_POWER_STATE];
      SETTINGS_OUT.speed_pwm_range_sel <= clk_gain_reg[`POS_SPEED_PWM_RANGE];
      SETTINGS_OUT.clock_source <= clock_source_t'(clk_gain_reg[`POS_CLOCK_SOURCE +: 2]);
      SETTINGS_OUT.ref_clock_mode_enable <= clk_gain_reg[`POS_REF_CLOCK_MODE];
      SETTINGS_OUT.ref_clock_rate_sel <= clk_gain_reg[`POS_REF_CLOCK_RATE +: 3];
      SETTINGS_OUT.current_amp_gain <= static_gain(gate_drv_reg);
      SETTINGS_OUT.auto_current_gain_enable <= auto_cur;
      SETTINGS_OUT.auto_voltage_gain_enable <= auto_volt;
      // accepted pwm span
      if (clk_gain_reg[`POS_SPEED_PWM_RANGE]) begin
        SETTINGS_OUT.speed_pwm_min_hz <= 32'(`SPEED_LOW_MIN_HZ);
        SETTINGS_OUT.speed_pwm_max_hz <= 32'(`SPEED_LOW_MAX_HZ);
      end else begin
        SETTINGS_OUT.speed_pwm_min_hz <= 32'(`SPEED_WIDE_MIN_HZ);
        SETTINGS_OUT.speed_pwm_max_hz <= 32'(`SPEED_WIDE_MAX_HZ);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin routing

  // shared pin and crystal pin pair
  always_ff @(posedge MCLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      PINS_OUT <= '0;
      CRYSTAL_ENABLE_OUT <= 1'b1;
    end else begin
      case (shared_sel)
        SHARED_MONITOR_B: PINS_OUT.shared_pin <= MONITOR_B_IN;
        SHARED_PHASE_A: PINS_OUT.shared_pin <= PHASE_A_SENSE_IN;
        SHARED_PHASE_B: PINS_OUT.shared_pin <= PHASE_B_SENSE_IN;
        SHARED_PHASE_C: PINS_OUT.shared_pin <= PHASE_C_SENSE_IN;
        default: PINS_OUT.shared_pin <= 1'b0;
      endcase
      if (pin_bus_reg[`POS_CRYSTAL_PIN_SEL]) begin
        PINS_OUT.pin_36 <= MONITOR_A_IN;
        PINS_OUT.pin_37 <= MONITOR_B_IN;
        CRYSTAL_ENABLE_OUT <= 1'b0;
      end else begin
        PINS_OUT.pin_36 <= 1'b0; // crystal input, not driven
        PINS_OUT.pin_37 <= CRYSTAL_DRIVE_IN;
        CRYSTAL_ENABLE_OUT <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // speed pin

  // two-stage synchroniser for the pin
  always_ff @(posedge MCLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      speed_sync_reg <= 2'h0;
    end else begin
      speed_sync_reg <= {speed_sync_reg[0], SPEED_PIN_IN};
    end
  end

  // role: speed command or wake only
  // the command keeps its last value while the pin only wakes,
  // so a change to the wake role never jolts the speed loop
  always_ff @(posedge MCLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      SPEED_CMD_OUT <= 1'b0;
      WAKE_OUT <= 1'b0;
    end else if (pin_bus_reg[`POS_SPEED_PIN_ROLE]) begin
      WAKE_OUT <= speed_sync_reg[1]; // command held
    end else begin
      SPEED_CMD_OUT <= speed_sync_reg[1];
      WAKE_OUT <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // gain re-evaluation

  // millisecond tick, free running
  // one shared counter keeps both strobes in phase, and toggling
  // an enable never stretches or shortens the period
  always_ff @(posedge MCLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      tick_cnt_reg <= '0;
    end else if (tick) begin
      tick_cnt_reg <= '0;
    end else begin
      tick_cnt_reg <= tick_cnt_reg + 1'b1;
    end
  end
  assign tick = (32'(tick_cnt_reg) == GAIN_EVAL_CYCLES - 1);

  // one-cycle evaluate strobes and the gain in force
  always_ff @(posedge MCLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      CURRENT_GAIN_EVAL_OUT <= 1'b0;
      VOLTAGE_GAIN_EVAL_OUT <= 1'b0;
      EFFECTIVE_CURRENT_GAIN_OUT <= 2'h0;
    end else begin
      CURRENT_GAIN_EVAL_OUT <= tick & auto_cur;
      VOLTAGE_GAIN_EVAL_OUT <= tick & auto_volt;
      if (auto_cur) begin
        EFFECTIVE_CURRENT_GAIN_OUT <= AUTO_CURRENT_GAIN_IN;
      end else begin
        EFFECTIVE_CURRENT_GAIN_OUT <= static_gain(gate_drv_reg);
      end
    end
  end
endmodule

// ---- hwcfg_chk_props.sv ----
// checker of the configuration bank
`timescale 1ns/1ns
`include "hwcfg_consts.svh"
module hwcfg_chk #(parameter int GAIN_EVAL_CYCLES = 16) (
  // clock, reset and port signals watched
  input wire logic MCLK_IN, RESETN_IN, WR_IN, RD_IN, MONITOR_A_IN, MONITOR_B_IN,
  input wire logic PHASE_A_SENSE_IN, PHASE_B_SENSE_IN, PHASE_C_SENSE_IN, CRYSTAL_DRIVE_IN,
  input wire logic SPEED_CMD_OUT, WAKE_OUT, CURRENT_GAIN_EVAL_OUT, VOLTAGE_GAIN_EVAL_OUT,
  input wire logic CRYSTAL_ENABLE_OUT,
  input wire logic [7:0] ADDR_IN,
  input wire logic [31:0] WDATA_IN, RDATA_OUT,
  input wire logic [1:0] AUTO_CURRENT_GAIN_IN, EFFECTIVE_CURRENT_GAIN_OUT,
  input wire hwcfg_pkg::pin_drive_t PINS_OUT,
  input wire hwcfg_pkg::hw_settings_t SETTINGS_OUT
);
  import hwcfg_pkg::*;
  logic [31:0] pin_w, clk_w, gd_w;
  int cnt;
  logic [3:0] mux;
  assign mux = {PHASE_C_SENSE_IN, PHASE_B_SENSE_IN, PHASE_A_SENSE_IN, MONITOR_B_IN};
  // shadow words and free-running tick count
  always_ff @(posedge MCLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      pin_w <= 32'h0;
      clk_w <= 32'h0;
      gd_w <= `RST_GATE_DRV;
      cnt <= 0;
    end else begin
      cnt <= (cnt == GAIN_EVAL_CYCLES - 1) ? 0 : cnt + 1;
      if (WR_IN && ADDR_IN == `OFS_PIN_BUS) pin_w <= WDATA_IN;
      if (WR_IN && ADDR_IN == `OFS_CLK_GAIN) clk_w <= WDATA_IN;
      if (WR_IN && ADDR_IN == `OFS_GATE_DRV) gd_w <= WDATA_IN;
    end
  end
  default clocking @(posedge MCLK_IN); endclocking
  default disable iff (!RESETN_IN);
  a_shared_route: assert property (
    $past(RESETN_IN) |-> PINS_OUT.shared_pin == $past(mux[pin_w[30:29]])) else $error("route");
  a_crystal_pins: assert property (
    $past(RESETN_IN) |-> CRYSTAL_ENABLE_OUT == !$past(pin_w[27])
    && PINS_OUT.pin_36 == $past(pin_w[27] & MONITOR_A_IN)
    && PINS_OUT.pin_37 == $past(pin_w[27] ? MONITOR_B_IN : CRYSTAL_DRIVE_IN)) else $error("xtal");
  a_wake_role: assert property (
    !$past(pin_w[28]) |-> !WAKE_OUT) else $error("wake");
  a_speed_hold: assert property (
    $past(pin_w[28]) |-> $stable(SPEED_CMD_OUT)) else $error("speed hold");
  a_current_tick: assert property (
    $past(RESETN_IN) && $past(cnt) == GAIN_EVAL_CYCLES - 1 && $past(clk_w[13], 2)
    && $past(clk_w[13]) |-> CURRENT_GAIN_EVAL_OUT) else $error("current tick");
  a_voltage_tick: assert property (
    $past(RESETN_IN) && $past(cnt) == GAIN_EVAL_CYCLES - 1 && $past(clk_w[12], 2)
    && $past(clk_w[12]) |-> VOLTAGE_GAIN_EVAL_OUT) else $error("voltage tick");
  a_ticks_quiet: assert property (
    $past(cnt) != GAIN_EVAL_CYCLES - 1 |-> !CURRENT_GAIN_EVAL_OUT && !VOLTAGE_GAIN_EVAL_OUT)
    else $error("tick spacing");
  a_gain_select: assert property (
    $past(RESETN_IN) && $past(clk_w[13]) == $past(clk_w[13], 2) && $past(gd_w[1:0]) ==
    $past(gd_w[1:0], 2) |-> EFFECTIVE_CURRENT_GAIN_OUT ==
    ($past(clk_w[13]) ? $past(AUTO_CURRENT_GAIN_IN) : $past(gd_w[1:0]))) else $error("gain");
  a_settings_map: assert property (
    $past(RESETN_IN) |-> SETTINGS_OUT.clock_source == $past(clk_w[9:8])
    && SETTINGS_OUT.ref_clock_mode_enable == $past(clk_w[6]) && SETTINGS_OUT.speed_pwm_max_hz
    == ($past(clk_w[10]) ? `SPEED_LOW_MAX_HZ : `SPEED_WIDE_MAX_HZ)) else $error("settings");
  a_read_word: assert property (
    RDATA_OUT == (!$past(RD_IN) ? 32'h0 : $past(ADDR_IN == `OFS_PIN_BUS ? pin_w :
    ADDR_IN == `OFS_CLK_GAIN ? clk_w : ADDR_IN == `OFS_GATE_DRV ? gd_w : 32'h0)))
    else $error("read data");
endmodule
bind hw_pin_clock_config_regs hwcfg_chk #(.GAIN_EVAL_CYCLES(GAIN_EVAL_CYCLES)) chk_u (.*);

// ---- testbench.sv ----
// self-checking bench of the configuration bank
`timescale 1ns/1ns
`include "hwcfg_consts.svh"
module testbench;
  import hwcfg_pkg::*;
  logic MCLK_IN = 0, RESETN_IN = 0, WR_IN = 0, RD_IN = 0, SPEED_PIN_IN = 0, cmd = 0;
  logic [7:0] ADDR_IN = 0;
  logic [31:0] WDATA_IN = 0, RDATA_OUT, v, g, nc, nv;
  logic [5:0] src = 0;
  logic [1:0] AUTO_CURRENT_GAIN_IN = 0, EFFECTIVE_CURRENT_GAIN_OUT;
  logic SPEED_CMD_OUT, WAKE_OUT, CURRENT_GAIN_EVAL_OUT, VOLTAGE_GAIN_EVAL_OUT, CRYSTAL_ENABLE_OUT;
  pin_drive_t PINS_OUT;
  hw_settings_t SETTINGS_OUT;
  int miscompares = 0, samples_checked = 0, seed = 22;
  hw_pin_clock_config_regs #(.GAIN_EVAL_CYCLES(16)) dut_u (.MCLK_IN, .RESETN_IN, .ADDR_IN,
    .WDATA_IN, .WR_IN, .RD_IN, .RDATA_OUT, .MONITOR_A_IN(src[0]), .MONITOR_B_IN(src[1]),
    .PHASE_A_SENSE_IN(src[2]), .PHASE_B_SENSE_IN(src[3]), .PHASE_C_SENSE_IN(src[4]),
    .CRYSTAL_DRIVE_IN(src[5]), .SPEED_PIN_IN, .AUTO_CURRENT_GAIN_IN, .SPEED_CMD_OUT, .WAKE_OUT,
    .CURRENT_GAIN_EVAL_OUT, .VOLTAGE_GAIN_EVAL_OUT, .EFFECTIVE_CURRENT_GAIN_OUT, .PINS_OUT,
    .CRYSTAL_ENABLE_OUT, .SETTINGS_OUT);
  // expected {shared, pin 36, pin 37} from the pin word and the sources
  function automatic logic [2:0] exp_pins(logic [31:0] w, logic [5:0] s);
    return {s[3'(w[30:29]) + 3'h1], w[27] & s[0], w[27] ? s[1] : s[5]};
  endfunction
  task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(logic [7:0] a, logic [31:0] d);
    @(posedge MCLK_IN);
    WR_IN <= 1'b1;
    ADDR_IN <= a;
    WDATA_IN <= d;
    @(posedge MCLK_IN);
    WR_IN <= 1'b0;
  endtask
  task automatic rd(logic [7:0] a, logic [31:0] exp);
    @(posedge MCLK_IN);
    RD_IN <= 1'b1;
    ADDR_IN <= a;
    @(posedge MCLK_IN);
    RD_IN <= 1'b0;
    @(negedge MCLK_IN);
    chk("rdata", exp, RDATA_OUT);
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // clock and hang guard
  initial forever #2 MCLK_IN = ~MCLK_IN;
  initial begin
    #100000;
    miscompares++;
    stop_test();
  end
  initial begin
    repeat (3) @(posedge MCLK_IN);
    RESETN_IN <= 1'b1;
    rd(`OFS_PIN_BUS, `RST_PIN_BUS);
    rd(`OFS_CLK_GAIN, `RST_CLK_GAIN);
    rd(`OFS_GATE_DRV, `RST_GATE_DRV);
    chk("xtal_en", 32'h1, 32'(CRYSTAL_ENABLE_OUT));
    $display("reset values done");
    // every code of the pin fields, random other bits and sources
    for (int i = 0; i < 16; i++) begin
      v = $random(seed);
      v[30:27] = i[3:0];
      wr(`OFS_PIN_BUS, v);
      src <= 6'($random(seed));
      SPEED_PIN_IN <= 1'($random(seed));
      repeat (2) @(posedge MCLK_IN);
      rd(`OFS_PIN_BUS, v);
      if (!v[28]) cmd = SPEED_PIN_IN;
      chk("pins", 32'(exp_pins(v, src)), 32'(PINS_OUT));
      chk("speed", 32'({cmd, v[28] & SPEED_PIN_IN}), 32'({SPEED_CMD_OUT, WAKE_OUT}));
      chk("xtal_en", 32'(!v[27]), 32'(CRYSTAL_ENABLE_OUT));
      chk("supply", 32'(v[1:0]), 32'(SETTINGS_OUT.max_supply_range));
    end
    $display("pin routing done");
    // modify one field of the word just read and write the whole word back
    v[30:29] = v[30:29] ^ 2'h3;
    wr(`OFS_PIN_BUS, v);
    rd(`OFS_PIN_BUS, v);
    $display("read modify write done");
    // clock source, span, reference mode and gain adjustment
    for (int i = 0; i < 8; i++) begin
      v = $random(seed);
      g = $random(seed);
      {v[13:12], v[10], v[9:8]} = {i[1:0], i[2], i[1:0]};
      wr(`OFS_CLK_GAIN, v);
      wr(`OFS_GATE_DRV, g);
      AUTO_CURRENT_GAIN_IN <= 2'($random(seed));
      rd(`OFS_CLK_GAIN, v);
      nc = 32'h0;
      nv = 32'h0;
      repeat (32) begin
        @(negedge MCLK_IN);
        nc += 32'(CURRENT_GAIN_EVAL_OUT);
        nv += 32'(VOLTAGE_GAIN_EVAL_OUT);
      end
      chk("cur_ticks", v[13] ? 32'h2 : 32'h0, nc);
      chk("volt_ticks", v[12] ? 32'h2 : 32'h0, nv);
      chk("gain", 32'(v[13] ? AUTO_CURRENT_GAIN_IN : g[1:0]),
        32'(EFFECTIVE_CURRENT_GAIN_OUT));
      chk("clk", 32'({v[9:8], v[6]}),
        32'({SETTINGS_OUT.clock_source, SETTINGS_OUT.ref_clock_mode_enable}));
      chk("min_hz", v[10] ? `SPEED_LOW_MIN_HZ : `SPEED_WIDE_MIN_HZ,
        SETTINGS_OUT.speed_pwm_min_hz);
      chk("max_hz", v[10] ? `SPEED_LOW_MAX_HZ : `SPEED_WIDE_MAX_HZ,
        SETTINGS_OUT.speed_pwm_max_hz);
      chk("modes", 32'({v[13:10], v[5:3], g[1:0]}),
        32'({SETTINGS_OUT.auto_current_gain_enable, SETTINGS_OUT.auto_voltage_gain_enable,
        SETTINGS_OUT.low_power_state_sel, SETTINGS_OUT.speed_pwm_range_sel,
        SETTINGS_OUT.ref_clock_rate_sel, SETTINGS_OUT.current_amp_gain}));
    end
    $display("clock and gain done");
    wr(8'ha4, 32'hffff_ffff);
    rd(8'ha4, 32'h0);
    rd(`OFS_GATE_DRV, g);
    $display("unmapped place done");
    // mid-run reset puts the pin and gate driver words, crystal enable and the speed outputs back to their reset values
    @(posedge MCLK_IN);
    RESETN_IN <= 1'b0;
    SPEED_PIN_IN <= 1'b0;
    repeat (3) @(posedge MCLK_IN);
    RESETN_IN <= 1'b1;
    rd(`OFS_PIN_BUS, `RST_PIN_BUS);
    rd(`OFS_GATE_DRV, `RST_GATE_DRV);
    chk("xtal_en", 32'h1, 32'(CRYSTAL_ENABLE_OUT));
    chk("speed", 32'h0, 32'({SPEED_CMD_OUT, WAKE_OUT}));
    $display("mid-run reset done");
    stop_test();
  end
endmodule
